// *** opvp_pkg.sv ***
package opvp_pkg;

  // ----------------------------------------------------------------
  // Clock and programming pulse timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned PROG_LOW_NOM_US = 100;
  localparam int unsigned PROG_LOW_TOL_US = 10;
  // Shortest strobe low time that still counts as a programming pulse.
  localparam int unsigned PROG_LOW_MIN_CYC = (PROG_LOW_NOM_US - PROG_LOW_TOL_US) * CLK_PER_US;
  localparam int unsigned LOW_CNT_W = 16;
  localparam logic [4:0] PROG_PULSES = 5'h19;

  // ----------------------------------------------------------------
  // Memory geometry and fixed locations
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned CODE_DEPTH = 16384;
  localparam int unsigned ENC_DEPTH = 32;
  localparam logic [ADDR_W-1:0] ENC_LAST_ADDR = 14'h001F;
  localparam logic [ADDR_W-1:0] SIG_ADDR0 = 14'h0030;
  localparam logic [ADDR_W-1:0] SIG_ADDR1 = 14'h0031;
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [7:0] DATA_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Mode line codes, ordered enable, select a, select b, select c
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_SIG = 4'h0;
  localparam logic [3:0] CODE_PGM = 4'hB;
  localparam logic [3:0] CODE_VERIFY = 4'h3;
  localparam logic [3:0] CODE_ENC = 4'hA;
  localparam logic [3:0] CODE_LOCK1 = 4'hF;
  localparam logic [3:0] CODE_LOCK2 = 4'hC;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    MODE_NONE   = 7'h01,
    MODE_SIG    = 7'h02,
    MODE_PGM    = 7'h04,
    MODE_VERIFY = 7'h08,
    MODE_ENC    = 7'h10,
    MODE_LOCK1  = 7'h20,
    MODE_LOCK2  = 7'h40
  } opvp_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_LOW    = 4'h2,
    ST_HIGH   = 4'h4,
    ST_COMMIT = 4'h8
  } opvp_state_t;

endpackage

// *** opvp_port.sv ***
`timescale 1ns/1ns
// Contract
// - Twenty-five strobe pulses commit one byte.
// - Encryption table written at addresses 0 to 1FH.
// - Programmed encryption table makes verify data scrambled.
// - Lock bit written by pulse train, station picks which.
// - Any lock bit blocks code and table writes.
// - One lock bit never blocks the other.
// - Verify readout only while lock bit 2 clear.
// - Verify mode drives stored byte on port 0.
// - Scrambled verify data is XNOR with table byte.
// - Encryption table has no readback path.
// - Signature bytes at 030H and 031H, select lines low.
// - Mode chosen from four mode-select line levels.
module opvp_port #(
  parameter int unsigned MIN_LOW_CYC = opvp_pkg::PROG_LOW_MIN_CYC,
  parameter logic [7:0] SIG_MAKER = 8'hA5, // Arbitrary identification value.
  parameter logic [7:0] SIG_PART = 8'h5A // Arbitrary identification value.
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control pins from the programming station
  input wire logic resetPin,
  input wire logic codeFetchStrobe,
  input wire logic latchProgramStrobe,
  input wire logic externalAccessProgramVoltage,
  input wire logic modeEnableLine,
  input wire logic modeSelectA,
  input wire logic modeSelectB,
  input wire logic modeSelectC,
  // Address and data pins
  input wire logic [7:0] port1In,
  input wire logic [5:0] port2In,
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic port0OutEnN,
  // Status
  output logic [1:0] lockBits,
  output logic encTableProgrammed,
  output logic writeDone
);

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  // Maps the four mode-select levels onto one-hot modes.
  function automatic opvp_pkg::opvp_mode_t decode_mode(input logic [3:0] lines);
    opvp_pkg::opvp_mode_t m;
    case (lines)
      opvp_pkg::CODE_SIG: m = opvp_pkg::MODE_SIG;
      opvp_pkg::CODE_PGM: m = opvp_pkg::MODE_PGM;
      opvp_pkg::CODE_VERIFY: m = opvp_pkg::MODE_VERIFY;
      opvp_pkg::CODE_ENC: m = opvp_pkg::MODE_ENC;
      opvp_pkg::CODE_LOCK1: m = opvp_pkg::MODE_LOCK1;
      opvp_pkg::CODE_LOCK2: m = opvp_pkg::MODE_LOCK2;
      default: m = opvp_pkg::MODE_NONE;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0] codeMem [opvp_pkg::CODE_DEPTH];
  logic [7:0] encTab [opvp_pkg::ENC_DEPTH];
  opvp_pkg::opvp_state_t state_q;
  opvp_pkg::opvp_state_t state_d;
  opvp_pkg::opvp_mode_t snapMode_q;
  logic [opvp_pkg::ADDR_W-1:0] snapAddr_q;
  logic [7:0] snapData_q;
  logic [4:0] pulseCnt_q;
  logic [4:0] pulseCnt_d;
  logic [opvp_pkg::LOW_CNT_W-1:0] lowCnt_q;
  logic [opvp_pkg::LOW_CNT_W-1:0] lowCnt_d;
  logic [1:0] lock_q;
  logic encProg_q;
  logic [7:0] port0Out_q;
  logic [7:0] port0Out_d;
  logic port0OutEnN_q;

  // ----------------------------------------------------------------
  // Pin qualification
  // ----------------------------------------------------------------
  // Mode lines count only while reset is high and fetch strobe is low.
  wire progActive = resetPin & ~codeFetchStrobe;
  wire opvp_pkg::opvp_mode_t modeNow =
    decode_mode({modeEnableLine, modeSelectA, modeSelectB, modeSelectC});
  wire [opvp_pkg::ADDR_W-1:0] addrNow = {port2In, port1In};
  wire isWriteMode = (modeNow == opvp_pkg::MODE_PGM) || (modeNow == opvp_pkg::MODE_ENC) ||
                     (modeNow == opvp_pkg::MODE_LOCK1) || (modeNow == opvp_pkg::MODE_LOCK2);
  // Writes also need the programming voltage present for the whole train.
  wire progMode = progActive & isWriteMode & externalAccessProgramVoltage;
  wire strobeLow = ~latchProgramStrobe;
  // Any change of address, data or mode during a train abandons it.
  wire trainStable = progMode && (modeNow == snapMode_q) && (addrNow == snapAddr_q) &&
                     (port0In == snapData_q);
  wire pulseLongEnough = lowCnt_q >= MIN_LOW_CYC[opvp_pkg::LOW_CNT_W-1:0];
  wire trainDone = pulseCnt_q == opvp_pkg::PROG_PULSES;

  // ----------------------------------------------------------------
  // Pulse train sequencer
  // ----------------------------------------------------------------
  // Counts qualified low pulses; glitches shorter than the minimum are not counted.
  always_comb begin
    state_d = state_q;
    pulseCnt_d = pulseCnt_q;
    lowCnt_d = lowCnt_q;
    case (state_q)
      opvp_pkg::ST_IDLE: begin
        pulseCnt_d = 5'h00;
        lowCnt_d = '0;
        // The edge that first sees the strobe low already counts one low cycle.
        if (progMode && strobeLow) begin
          state_d = opvp_pkg::ST_LOW;
          lowCnt_d = {{(opvp_pkg::LOW_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      opvp_pkg::ST_LOW: begin
        if (!trainStable) begin
          state_d = opvp_pkg::ST_IDLE;
        end else if (!strobeLow) begin
          state_d = opvp_pkg::ST_HIGH;
          if (pulseLongEnough) begin
            pulseCnt_d = pulseCnt_q + 5'h01;
          end
        end else if (!(&lowCnt_q)) begin
          lowCnt_d = lowCnt_q + 1'b1;
        end
      end
      opvp_pkg::ST_HIGH: begin
        if (!trainStable) begin
          state_d = opvp_pkg::ST_IDLE;
        end else if (trainDone) begin
          state_d = opvp_pkg::ST_COMMIT;
        end else if (strobeLow) begin
          state_d = opvp_pkg::ST_LOW;
          lowCnt_d = {{(opvp_pkg::LOW_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      opvp_pkg::ST_COMMIT: begin
        state_d = opvp_pkg::ST_IDLE;
      end
      default: begin
        state_d = opvp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; the snapshot is taken as the first pulse starts.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= opvp_pkg::ST_IDLE;
      pulseCnt_q <= 5'h00;
      lowCnt_q <= '0;
      snapMode_q <= opvp_pkg::MODE_NONE;
      snapAddr_q <= '0;
      snapData_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pulseCnt_q <= pulseCnt_d;
      lowCnt_q <= lowCnt_d;
      if (state_q == opvp_pkg::ST_IDLE) begin
        snapMode_q <= modeNow;
        snapAddr_q <= addrNow;
        snapData_q <= port0In;
      end
    end
  end

  // ----------------------------------------------------------------
  // Commit decoding
  // ----------------------------------------------------------------
  // Either lock bit shuts code and table writes; lock writes stay open.
  wire commit = state_q == opvp_pkg::ST_COMMIT;
  wire lockAny = |lock_q;
  wire codeWr = commit && (snapMode_q == opvp_pkg::MODE_PGM) && !lockAny;
  wire encWr = commit && (snapMode_q == opvp_pkg::MODE_ENC) && !lockAny &&
               (snapAddr_q <= opvp_pkg::ENC_LAST_ADDR);
  wire lock1Wr = commit && (snapMode_q == opvp_pkg::MODE_LOCK1);
  wire lock2Wr = commit && (snapMode_q == opvp_pkg::MODE_LOCK2);

  // Array contents are not reset, as befits nonvolatile cells.
  always_ff @(posedge ref_clk) begin
    if (codeWr) begin
      codeMem[snapAddr_q] <= snapData_q;
    end
    if (encWr) begin
      encTab[snapAddr_q[4:0]] <= snapData_q;
    end
  end

  // Lock and table flags; reset stands for a blank part in simulation.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_q <= opvp_pkg::LOCK_RST;
      encProg_q <= 1'b0;
    end else begin
      lock_q <= lock_q | {lock2Wr, lock1Wr};
      encProg_q <= encProg_q | encWr;
    end
  end

  // ----------------------------------------------------------------
  // Verify and signature readout
  // ----------------------------------------------------------------
  // The table byte only ever reaches port 0 mixed with code, never alone.
  wire [7:0] rdCode = codeMem[addrNow];
  wire [7:0] encByte = encTab[addrNow[4:0]];
  wire [7:0] verifyData = encProg_q ? ~(rdCode ^ encByte) : rdCode;
  wire [7:0] sigData = (addrNow == opvp_pkg::SIG_ADDR0) ? SIG_MAKER :
                       (addrNow == opvp_pkg::SIG_ADDR1) ? SIG_PART : opvp_pkg::DATA_IDLE;
  wire readSig = progActive && (modeNow == opvp_pkg::MODE_SIG);
  wire readCode = progActive && (modeNow == opvp_pkg::MODE_VERIFY) && !lock_q[1];
  assign port0Out_d = readSig ? sigData : readCode ? verifyData : opvp_pkg::DATA_IDLE;

  // Port 0 data and enable are registered so the pins never glitch.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port0Out_q <= opvp_pkg::DATA_IDLE;
      port0OutEnN_q <= 1'b1;
    end else begin
      port0Out_q <= port0Out_d;
      port0OutEnN_q <= !(readSig || readCode);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port0Out = port0Out_q;
  assign port0OutEnN = port0OutEnN_q;
  assign lockBits = lock_q;
  assign encTableProgrammed = encProg_q;
  assign writeDone = commit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Bytes at the snapshot address, watched across a refused commit.
  wire [7:0] snapCode = codeMem[snapAddr_q];
  wire [7:0] snapEnc = encTab[snapAddr_q[4:0]];

  // Last counted pulse in place with inputs still steady.
  sequence s_train_end;
    (state_q == opvp_pkg::ST_HIGH) && trainDone && trainStable;
  endsequence

  sequence s_commit_then_idle;
    (state_q == opvp_pkg::ST_COMMIT) ##1 (state_q == opvp_pkg::ST_IDLE);
  endsequence

  a_train_commits: assert property (s_train_end |=> s_commit_then_idle)
    else $error("Completed pulse train did not commit.");

  a_commit_count: assert property (commit |-> pulseCnt_q == opvp_pkg::PROG_PULSES)
    else $error("Commit without the full pulse count.");

  // A commit under any lock must leave both arrays untouched at its address.
  a_lock_blocks_write: assert property (
    (commit && lockAny) |=> ((snapCode === $past(snapCode)) && (snapEnc === $past(snapEnc))))
    else $error("Write accepted while locked.");

  // Table writes only ever land in the low thirty-two locations.
  a_enc_range: assert property (encWr |-> snapAddr_q[opvp_pkg::ADDR_W-1:5] == '0)
    else $error("Table write outside its address range.");

  // Lock bit 2 must still be taken after lock bit 1 is set.
  a_second_lock: assert property ((lock_q[0] && lock2Wr) |=> (lock_q == 2'h3))
    else $error("Second lock bit refused.");

  // A lock bit once set stays set, so refused writes stay refused.
  a_lock_sticky: assert property (|lock_q |=> ((lock_q & $past(lock_q)) == $past(lock_q)))
    else $error("Lock bit cleared.");

  a_verify_locked: assert property (
    (progActive && modeNow == opvp_pkg::MODE_VERIFY && lock_q[1]) |=> port0OutEnN_q)
    else $error("Verify read allowed with lock bit 2 set.");

  a_verify_plain: assert property (
    (readCode && !encProg_q) |=> (!port0OutEnN_q && port0Out_q == $past(rdCode)))
    else $error("Verify data differs from stored byte.");

  a_verify_scramble: assert property (
    (readCode && encProg_q) |=> (port0Out_q == ~($past(rdCode) ^ $past(encByte))))
    else $error("Verify data not scrambled.");

  a_sig_bytes: assert property (
    (readSig && addrNow == opvp_pkg::SIG_ADDR0) |=> (port0Out_q == SIG_MAKER) ##0 !port0OutEnN_q)
    else $error("Wrong first identification byte.");

  a_inactive_quiet: assert property (
    !progActive |=> (port0OutEnN_q && state_q != opvp_pkg::ST_COMMIT))
    else $error("Port active outside programming conditions.");

endmodule

// *** opvp_station.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Programming station model
// ----------------------------------------------------------------
module opvp_station (
  // Clock
  input wire logic ref_clk,
  // Pins toward the device
  output logic resetPin,
  output logic codeFetchStrobe,
  output logic latchProgramStrobe,
  output logic externalAccessProgramVoltage,
  output logic [3:0] modeLines,
  output logic [13:0] addr,
  output logic [7:0] wrData
);
  // The part is held inactive until the bench asks for an operation.
  initial begin
    resetPin = 1'b0;
    codeFetchStrobe = 1'b1;
    latchProgramStrobe = 1'b1;
    externalAccessProgramVoltage = 1'b0;
    modeLines = 4'h0;
    addr = 14'h0000;
    wrData = 8'h00;
  end

  // Applies levels on an edge and holds them one more cycle before any strobe.
  task automatic setPins(input logic act, input logic [3:0] m, input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    resetPin <= act;
    codeFetchStrobe <= ~act;
    externalAccessProgramVoltage <= 1'b1;
    modeLines <= m;
    addr <= a;
    wrData <= d;
    @(posedge ref_clk);
  endtask

  // Levels stay untouched for the whole train, so only the strobe moves.
  task automatic pulses(input int n, input int lowCyc);
    repeat (n) begin
      latchProgramStrobe <= 1'b0;
      repeat (lowCyc) @(posedge ref_clk);
      latchProgramStrobe <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // The bench clock runs at the part's own 50 MHz; only the minimum strobe low time is cut, to four cycles.
  localparam logic [7:0] SIG_M = 8'h3E; // Arbitrary identification value.
  localparam logic [7:0] SIG_P = 8'hD1; // Arbitrary identification value.
  typedef struct packed {logic [13:0] a; logic [7:0] d;} opvp_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic rstPin, fetch, strobe, vpp, enN, encDone, wDone;
  logic [3:0] modes;
  logic [13:0] addr;
  logic [7:0] wrData, rdData;
  logic [1:0] locks;
  logic [7:0] encTab [32];
  opvp_row_t rows [4] = '{'{14'h0000, 8'h3C}, '{14'h3FFF, 8'hC3}, '{14'h0001, 8'hFF}, '{14'h2A55, 8'h00}};
  int error_cnt = 0;
  int total_checks = 0;
  int doneCnt = 0;
  int expDone = 0;

  always #10 ref_clk = ~ref_clk;

  // Commit pulses are counted so that aborted trains can be told apart.
  always @(posedge ref_clk) if (wDone === 1'b1) doneCnt++;

  opvp_station opvp_station_inst (.ref_clk(ref_clk), .resetPin(rstPin), .codeFetchStrobe(fetch),
    .latchProgramStrobe(strobe), .externalAccessProgramVoltage(vpp), .modeLines(modes), .addr(addr),
    .wrData(wrData));

  opvp_port #(.MIN_LOW_CYC(4), .SIG_MAKER(SIG_M), .SIG_PART(SIG_P)) opvp_port_inst (.ref_clk(ref_clk),
    .srst(srst), .resetPin(rstPin), .codeFetchStrobe(fetch), .latchProgramStrobe(strobe),
    .externalAccessProgramVoltage(vpp), .modeEnableLine(modes[3]), .modeSelectA(modes[2]),
    .modeSelectB(modes[1]), .modeSelectC(modes[0]), .port1In(addr[7:0]), .port2In(addr[13:8]),
    .port0In(wrData), .port0Out(rdData), .port0OutEnN(enN), .lockBits(locks),
    .encTableProgrammed(encDone), .writeDone(wDone));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compares two bytes with case equality, so an unknown never matches.
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Reads one cycle after the levels land, the registered latency of the read path.
  task automatic rd(input logic [3:0] m, input logic [13:0] a, input logic [7:0] exp, input logic en);
    opvp_station_inst.setPins(1'b1, m, a, 8'h00);
    #1;
    check({7'h00, enN}, {7'h00, en}, "drive enable");
    check(rdData, exp, "read data");
  endtask

  // One full train; returns just past the closing edge so counters and flags have settled.
  task automatic wr(input logic [3:0] m, input logic [13:0] a, input logic [7:0] d);
    opvp_station_inst.setPins(1'b1, m, a, d);
    opvp_station_inst.pulses(25, 6);
    #1;
    expDone++;
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // About five times the expected run length, so only a real hang gets here.
  initial begin
    #1_000_000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check({6'h00, locks}, 8'h00, "lock reset");
    check({7'h00, encDone}, 8'h00, "table flag reset");
    check({7'h00, enN}, 8'h01, "idle drive");
    $display("reset test done");
    // Plain program and verify, including the top address.
    foreach (rows[i]) begin
      wr(opvp_pkg::CODE_PGM, rows[i].a, rows[i].d);
      check(8'(doneCnt), 8'(expDone), "commit count");
      rd(opvp_pkg::CODE_VERIFY, rows[i].a, rows[i].d, 1'b0);
    end
    $display("row test done");
    // A train broken after 24 pulses must leave the byte alone.
    opvp_station_inst.setPins(1'b1, opvp_pkg::CODE_PGM, 14'h0000, 8'h99);
    opvp_station_inst.pulses(24, 6);
    rd(opvp_pkg::CODE_VERIFY, 14'h0000, 8'h3C, 1'b0);
    check(8'(doneCnt), 8'(expDone), "aborted train");
    // Pulses shorter than the minimum low time are not counted.
    opvp_station_inst.setPins(1'b1, opvp_pkg::CODE_PGM, 14'h0001, 8'h12);
    opvp_station_inst.pulses(25, 2);
    rd(opvp_pkg::CODE_VERIFY, 14'h0001, 8'hFF, 1'b0);
    $display("abort test done");
    rd(opvp_pkg::CODE_SIG, 14'h0030, SIG_M, 1'b0);
    rd(opvp_pkg::CODE_SIG, 14'h0031, SIG_P, 1'b0);
    $display("signature test done");
    // Whole table, then scrambled readback of every stored row.
    for (int i = 0; i < 32; i++) begin
      encTab[i] = 8'(i * 37 + 5);
      wr(opvp_pkg::CODE_ENC, 14'(i), encTab[i]);
    end
    check({7'h00, encDone}, 8'h01, "table flag");
    foreach (rows[i]) rd(opvp_pkg::CODE_VERIFY, rows[i].a, ~(rows[i].d ^ encTab[rows[i].a[4:0]]), 1'b0);
    rd(opvp_pkg::CODE_SIG, 14'h0005, 8'h00, 1'b0);
    $display("table test done");
    // After lock 1 both code and table writes are dropped.
    wr(opvp_pkg::CODE_LOCK1, 14'h0000, 8'h00);
    check({6'h00, locks}, 8'h01, "lock 1 set");
    wr(opvp_pkg::CODE_PGM, 14'h0000, 8'h77);
    wr(opvp_pkg::CODE_ENC, 14'h0000, 8'h00);
    rd(opvp_pkg::CODE_VERIFY, 14'h0000, ~(8'h3C ^ encTab[0]), 1'b0);
    wr(opvp_pkg::CODE_LOCK2, 14'h0000, 8'h00);
    check({6'h00, locks}, 8'h03, "lock 2 set");
    rd(opvp_pkg::CODE_VERIFY, 14'h0000, 8'h00, 1'b1);
    $display("lock test done");
    // With the reset pin low the mode lines are ignored.
    opvp_station_inst.setPins(1'b0, opvp_pkg::CODE_SIG, 14'h0030, 8'h00);
    #1;
    check({7'h00, enN}, 8'h01, "inactive drive");
    check(rdData, 8'h00, "inactive data");
    $display("inactive test done");
    close_out();
  end
endmodule
